// file: common/touch_defines.svh
// Offsets, reset values and scaling constants of the adaptive threshold block.
// Assumes inclusion by bare name from files that need the register map.
`ifndef TOUCH_DEFINES_SVH
`define TOUCH_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_STAGE_SEL   8'h00
`define OFS_POS_SENS    8'h04
`define OFS_NEG_SENS    8'h08
`define OFS_POS_WIN     8'h0C
`define OFS_NEG_WIN     8'h10
`define OFS_UP_OFF      8'h14
`define OFS_LO_OFF      8'h18
`define OFS_UP_LIM      8'h1C
`define OFS_LO_LIM      8'h20
`define OFS_AMBIENT     8'h24
`define OFS_UP_THR      8'h28
`define OFS_LO_THR      8'h2C
`define OFS_UPD_LVL     8'h30
`define OFS_CONTACT     8'h34

// ----------------------------------------------------------------------------
// Reset values and scaling
// ----------------------------------------------------------------------------
`define RST_SENS        4'h8
`define RST_WIN         16'h0040
`define RST_UP_LIM      16'h0400
`define RST_LO_LIM      16'h0400
`define RST_UPD_LVL     16'h0004
`define AMB_SHIFT       3
`define AVG_SHIFT       2
`define WIN_SHIFT       8

`endif

// file: common/touch_pkg.sv
// Types shared by the adaptive threshold block.
// Assumes nothing of its surroundings.
package touch_pkg;

    typedef logic signed [17:0] wide_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  stage;
        logic [15:0] code;
    } sample_s;

    typedef struct packed {
        logic [3:0]  pos_sens;
        logic [3:0]  neg_sens;
        logic [15:0] pos_win;
        logic [15:0] neg_win;
        logic [15:0] up_lim;
        logic [15:0] lo_lim;
        logic [15:0] upd_lvl;
    } config_s;

endpackage

// file: design/threshold_calc.sv
// Threshold arithmetic: ambient plus scaled stage offset, saturated to 16 bits.
// Assumes a signed offset and an unsigned ambient from the caller.
module threshold_calc (
    // Operands
    input  wire logic [15:0]          ambient,
    input  wire touch_pkg::wide_t     offset,
    input  wire logic [3:0]           sens,
    // Result
    output logic [15:0]               threshold
);
    import touch_pkg::*;

    logic signed [22:0] quarter;
    logic signed [22:0] rest;
    logic signed [22:0] scaled;
    logic signed [22:0] total;

    always_comb begin
        quarter = 23'(offset) >>> 2;
        rest    = (23'(offset) - quarter) >>> 4;
        scaled  = rest * $signed({19'd0, sens});
        total   = $signed({7'd0, ambient}) + quarter + scaled;
        if (total < 0) begin
            threshold = 16'h0000;
        end else if (total > $signed(23'h00_FFFF)) begin
            threshold = 16'hFFFF;
        end else begin
            threshold = total[15:0];
        end
    end

endmodule // threshold_calc

// file: design/adaptive_touch_threshold.sv
// Adaptive touch threshold engine with an AHB-Lite register slave.
// Assumes converter samples on hclk, one per cycle at most, tagged by stage.
`include "touch_defines.svh"

module adaptive_touch_threshold #(
    parameter int NUM_STAGES = 12
) (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Converter samples
    input  wire touch_pkg::sample_s    sample,
    // Contact flags
    output logic [NUM_STAGES-1:0]      contact_high,
    output logic [NUM_STAGES-1:0]      contact_low
);
    import touch_pkg::*;

    if (NUM_STAGES < 1 || NUM_STAGES > 16) begin : g_bad_stages
        $error("NUM_STAGES must lie between 1 and 16");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    config_s               cfg_reg;
    logic [3:0]            sel_reg;
    logic                  wr_pend_reg;
    logic [7:0]            addr_reg;
    logic [15:0]           amb_reg      [NUM_STAGES];
    logic [15:0]           last_push_reg[NUM_STAGES];
    wide_t                 avg_max_reg  [NUM_STAGES];
    wide_t                 avg_min_reg  [NUM_STAGES];
    wide_t                 up_off_reg   [NUM_STAGES];
    wide_t                 lo_off_reg   [NUM_STAGES];
    logic [15:0]           up_thr_reg   [NUM_STAGES];
    logic [15:0]           lo_thr_reg   [NUM_STAGES];
    logic [NUM_STAGES-1:0] seeded_reg;
    logic [NUM_STAGES-1:0] contact_high_reg;
    logic [NUM_STAGES-1:0] contact_low_reg;
    logic [3:0]            calc_stage_reg;
    logic                  calc_pend_reg;

    function automatic wide_t mag(input wide_t v);
        mag = (v < 0) ? -v : v;
    endfunction

    // ------------------------------------------------------------------------
    // Sample path
    // ------------------------------------------------------------------------
    logic [3:0]         s;
    logic               take;
    wide_t              cur;
    wide_t              amb_w;
    wide_t              amb_next;
    logic               push;
    wide_t              max_cur;
    wide_t              min_cur;
    logic signed [26:0] max_win_p;
    logic signed [26:0] min_win_p;
    logic               upd_max;
    logic               upd_min;
    wide_t              max_next;
    wide_t              min_next;
    wide_t              up_off_next;
    wide_t              lo_off_next;
    wide_t              up_lim_w;
    wide_t              lo_lim_w;

    assign s        = sample.stage;
    assign take     = sample.valid && (32'(s) < NUM_STAGES);
    assign cur      = $signed({2'b00, sample.code});
    assign amb_w    = $signed({2'b00, amb_reg[s]});
    assign max_cur  = avg_max_reg[s];
    assign min_cur  = avg_min_reg[s];
    assign up_lim_w = $signed({2'b00, cfg_reg.up_lim});
    assign lo_lim_w = -$signed({2'b00, cfg_reg.lo_lim});

    always_comb begin
        // Slow filter entry and ambient tracking
        push      = mag(cur - $signed({2'b00, last_push_reg[s]})) >
                    $signed({2'b00, cfg_reg.upd_lvl});
        amb_next  = push ? amb_w + ((cur - amb_w) >>> `AMB_SHIFT) : amb_w;
        // Peak windows as a fraction of the span from ambient
        max_win_p = 27'(max_cur - amb_w) * $signed({11'd0, cfg_reg.pos_win});
        min_win_p = 27'(min_cur - amb_w) * $signed({11'd0, cfg_reg.neg_win});
        upd_max   = mag(cur - max_cur) <=
                    mag(wide_t'(max_win_p >>> `WIN_SHIFT));
        upd_min   = mag(cur - min_cur) <=
                    mag(wide_t'(min_win_p >>> `WIN_SHIFT));
        max_next  = upd_max ? max_cur + ((cur - max_cur) >>> `AVG_SHIFT)
                            : max_cur;
        min_next  = upd_min ? min_cur + ((cur - min_cur) >>> `AVG_SHIFT)
                            : min_cur;
        // Offsets follow the averages, bounded by the limits
        up_off_next = max_next - amb_w;
        lo_off_next = min_next - amb_w;
        if (up_off_next > up_lim_w) begin
            up_off_next = up_lim_w;
        end
        if (lo_off_next < lo_lim_w) begin
            lo_off_next = lo_lim_w;
        end
    end

    // ------------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------------
    logic        addr_ok;
    logic        wr_up;
    logic        wr_lo;
    logic [31:0] rd_mux;

    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_up     = wr_pend_reg && addr_reg == `OFS_UP_OFF && 32'(sel_reg) < NUM_STAGES;
    assign wr_lo     = wr_pend_reg && addr_reg == `OFS_LO_OFF && 32'(sel_reg) < NUM_STAGES;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `OFS_STAGE_SEL: rd_mux = {28'h000_0000, sel_reg};
            `OFS_POS_SENS:  rd_mux = {28'h000_0000, cfg_reg.pos_sens};
            `OFS_NEG_SENS:  rd_mux = {28'h000_0000, cfg_reg.neg_sens};
            `OFS_POS_WIN:   rd_mux = {16'h0000, cfg_reg.pos_win};
            `OFS_NEG_WIN:   rd_mux = {16'h0000, cfg_reg.neg_win};
            `OFS_UP_LIM:    rd_mux = {16'h0000, cfg_reg.up_lim};
            `OFS_LO_LIM:    rd_mux = {16'h0000, cfg_reg.lo_lim};
            `OFS_UPD_LVL:   rd_mux = {16'h0000, cfg_reg.upd_lvl};
            `OFS_CONTACT:   rd_mux = {16'(contact_low_reg), 16'(contact_high_reg)};
            default:        rd_mux = 32'h0000_0000;
        endcase
        if (32'(sel_reg) < NUM_STAGES) begin
            case (haddr[7:0])
                `OFS_UP_OFF:  rd_mux = {16'h0000, up_off_reg[sel_reg][15:0]};
                `OFS_LO_OFF:  rd_mux = {16'h0000, lo_off_reg[sel_reg][15:0]};
                `OFS_AMBIENT: rd_mux = {16'h0000, amb_reg[sel_reg]};
                `OFS_UP_THR:  rd_mux = {16'h0000, up_thr_reg[sel_reg]};
                `OFS_LO_THR:  rd_mux = {16'h0000, lo_thr_reg[sel_reg]};
                default:      rd_mux = rd_mux;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            hrdata      <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok) begin
                addr_reg <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_reg          <= 4'h0;
            cfg_reg.pos_sens <= `RST_SENS;
            cfg_reg.neg_sens <= `RST_SENS;
            cfg_reg.pos_win  <= `RST_WIN;
            cfg_reg.neg_win  <= `RST_WIN;
            cfg_reg.up_lim   <= `RST_UP_LIM;
            cfg_reg.lo_lim   <= `RST_LO_LIM;
            cfg_reg.upd_lvl  <= `RST_UPD_LVL;
        end else if (wr_pend_reg) begin
            case (addr_reg)
                `OFS_STAGE_SEL: sel_reg          <= hwdata[3:0];
                `OFS_POS_SENS:  cfg_reg.pos_sens <= hwdata[3:0];
                `OFS_NEG_SENS:  cfg_reg.neg_sens <= hwdata[3:0];
                `OFS_POS_WIN:   cfg_reg.pos_win  <= hwdata[15:0];
                `OFS_NEG_WIN:   cfg_reg.neg_win  <= hwdata[15:0];
                `OFS_UP_LIM:    cfg_reg.up_lim   <= hwdata[15:0];
                `OFS_LO_LIM:    cfg_reg.lo_lim   <= hwdata[15:0];
                `OFS_UPD_LVL:   cfg_reg.upd_lvl  <= hwdata[15:0];
                default:        sel_reg          <= sel_reg;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Per-stage tracking; a host offset load wins over calibration
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seeded_reg <= '0;
            for (int i = 0; i < NUM_STAGES; i++) begin
                amb_reg[i]       <= 16'h0000;
                last_push_reg[i] <= 16'h0000;
                avg_max_reg[i]   <= '0;
                avg_min_reg[i]   <= '0;
                up_off_reg[i]    <= '0;
                lo_off_reg[i]    <= '0;
            end
        end else begin
            if (take && !seeded_reg[s]) begin
                seeded_reg[s]    <= 1'b1;
                amb_reg[s]       <= sample.code;
                last_push_reg[s] <= sample.code;
                avg_max_reg[s]   <= cur + up_off_reg[s];
                avg_min_reg[s]   <= cur + lo_off_reg[s];
            end else if (take) begin
                amb_reg[s]     <= amb_next[15:0];
                avg_max_reg[s] <= max_next;
                avg_min_reg[s] <= min_next;
                up_off_reg[s]  <= up_off_next;
                lo_off_reg[s]  <= lo_off_next;
                if (push) begin
                    last_push_reg[s] <= sample.code;
                end
            end
            if (wr_up) begin
                up_off_reg[sel_reg]  <= $signed({{2{hwdata[15]}}, hwdata[15:0]});
                avg_max_reg[sel_reg] <= $signed({2'b00, amb_reg[sel_reg]}) +
                                        $signed({{2{hwdata[15]}}, hwdata[15:0]});
            end
            if (wr_lo) begin
                lo_off_reg[sel_reg]  <= $signed({{2{hwdata[15]}}, hwdata[15:0]});
                avg_min_reg[sel_reg] <= $signed({2'b00, amb_reg[sel_reg]}) +
                                        $signed({{2{hwdata[15]}}, hwdata[15:0]});
            end
        end
    end

    // ------------------------------------------------------------------------
    // Threshold recompute, one cycle after an update; a sample and an offset load together recompute only the sampled stage
    // ------------------------------------------------------------------------
    logic [15:0] up_thr_calc;
    logic [15:0] lo_thr_calc;

    threshold_calc u_up_calc (
        .ambient   (amb_reg[calc_stage_reg]),
        .offset    (up_off_reg[calc_stage_reg]),
        .sens      (cfg_reg.pos_sens),
        .threshold (up_thr_calc)
    );

    threshold_calc u_lo_calc (
        .ambient   (amb_reg[calc_stage_reg]),
        .offset    (lo_off_reg[calc_stage_reg]),
        .sens      (cfg_reg.neg_sens),
        .threshold (lo_thr_calc)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            calc_stage_reg <= 4'h0;
            calc_pend_reg  <= 1'b0;
        end else begin
            calc_pend_reg <= take || wr_up || wr_lo;
            if (take) begin
                calc_stage_reg <= s;
            end else if (wr_up || wr_lo) begin
                calc_stage_reg <= sel_reg;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_STAGES; i++) begin
                up_thr_reg[i] <= 16'hFFFF;
                lo_thr_reg[i] <= 16'h0000;
            end
        end else if (calc_pend_reg && 32'(calc_stage_reg) < NUM_STAGES) begin
            up_thr_reg[calc_stage_reg] <= up_thr_calc;
            lo_thr_reg[calc_stage_reg] <= lo_thr_calc;
        end
    end

    // ------------------------------------------------------------------------
    // Contact detection
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            contact_high_reg <= '0;
            contact_low_reg  <= '0;
        end else if (take && seeded_reg[s]) begin
            contact_high_reg[s] <= sample.code > up_thr_reg[s];
            contact_low_reg[s]  <= sample.code < lo_thr_reg[s];
        end
    end

    assign contact_high = contact_high_reg;
    assign contact_low  = contact_low_reg;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence live_sample;
        take && seeded_reg[s] && !wr_up && !wr_lo;
    endsequence

    contact_high_a: assert property (
        take && seeded_reg[s] && sample.code > up_thr_reg[s]
        |=> contact_high_reg[calc_stage_reg])
        else $error("high contact not flagged");

    thr_recompute_a: assert property (
        live_sample and upd_max
        |=> calc_pend_reg ##1 up_thr_reg[$past(calc_stage_reg)] == $past(up_thr_calc))
        else $error("high threshold not recomputed");

    low_threshold_a: assert property (
        calc_pend_reg && 32'(calc_stage_reg) < NUM_STAGES
        |=> lo_thr_reg[$past(calc_stage_reg)] == $past(lo_thr_calc))
        else $error("low threshold not stored");

    slow_gate_a: assert property (
        live_sample and !push |=> amb_reg[calc_stage_reg] == $past(amb_w[15:0]))
        else $error("ambient moved without a push");

    min_window_a: assert property (
        live_sample and !upd_min |=> avg_min_reg[calc_stage_reg] == $past(min_cur))
        else $error("average minimum moved outside window");

    max_window_a: assert property (
        live_sample and !upd_max |=> avg_max_reg[calc_stage_reg] == $past(max_cur))
        else $error("average maximum moved outside window");

    offset_limit_a: assert property (
        live_sample |=> up_off_reg[calc_stage_reg] <= $past(up_lim_w)
                        && lo_off_reg[calc_stage_reg] >= $past(lo_lim_w))
        else $error("offset beyond limit");

    offset_drift_a: assert property (
        live_sample and upd_max |=> up_off_reg[calc_stage_reg] == $past(up_off_next))
        else $error("upper offset not recalibrated");

endmodule // adaptive_touch_threshold

// file: sim/converter_model.sv
// Stand-in for the capacitance converter: one tagged sample per call.
// Assumes each call starts just after a rising edge of hclk.
module converter_model (
    // Clock
    input  wire logic                hclk,
    // Sample towards the block
    output touch_pkg::sample_s       sample
);
    timeunit 1ns;
    timeprecision 1ps;
    import touch_pkg::*;

    initial sample = '0;

    // ------------------------------------------------------------------
    // Sample delivery
    // ------------------------------------------------------------------
    task automatic send(input logic [3:0] stage, input logic [15:0] code);
        sample <= '{valid: 1'b1, stage: stage, code: code};
        @(posedge hclk);
        // Idle port shows the inverse so a stale code never looks fresh
        sample <= '{valid: 1'b0, stage: ~stage, code: ~code};
        @(posedge hclk);
        @(posedge hclk);
    endtask
endmodule // converter_model

// file: sim/adaptive_touch_threshold_test.sv
// Self-checking bench of the adaptive threshold block over AHB-Lite.
// Assumes a zero wait state slave and the converter model beside it.
`include "touch_defines.svh"

module adaptive_touch_threshold_test;
    timeunit 1ns;
    timeprecision 1ps;
    import touch_pkg::*;

    logic               hclk;
    logic               hresetn;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               hresp;
    logic               last_resp;
    sample_s            sample;
    logic [11:0]        contact_high;
    logic [11:0]        contact_low;
    int                 fails;
    int                 compares;

    adaptive_touch_threshold #(.NUM_STAGES(12)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sample(sample), .contact_high(contact_high), .contact_low(contact_low));

    converter_model cm (.hclk(hclk), .sample(sample));

    always #12.5 hclk = ~hclk;

    // ------------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------------
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        hsize  <= 3'b010;
        htrans <= 2'b10;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
        last_resp = hresp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0000_0000, v);
        check_reg(v, exp);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        rd_exp(`OFS_POS_SENS, 32'h0000_0008);
        rd_exp(`OFS_NEG_SENS, 32'h0000_0008);
        rd_exp(`OFS_POS_WIN, 32'h0000_0040);
        rd_exp(`OFS_NEG_WIN, 32'h0000_0040);
        rd_exp(`OFS_UP_LIM, 32'h0000_0400);
        rd_exp(`OFS_LO_LIM, 32'h0000_0400);
        rd_exp(`OFS_UPD_LVL, 32'h0000_0004);
        rd_exp(`OFS_UP_THR, 32'h0000_FFFF);
        rd_exp(`OFS_LO_THR, 32'h0000_0000);
        rd_exp(8'h3C, 32'h0000_0000);
        check_flag(last_resp, 1'b0);
        $display("test reset done");
    endtask

    task automatic test_sensitivity();
        wr(`OFS_STAGE_SEL, 32'h0000_0001);
        wr(`OFS_UP_OFF, 32'h0000_0100);
        wr(`OFS_LO_OFF, 32'h0000_FF00);
        cm.send(4'h1, 16'h1000);
        rd_exp(`OFS_AMBIENT, 32'h0000_1000);
        for (int k = 0; k < 16; k++) begin
            wr(`OFS_POS_SENS, 32'(k));
            wr(`OFS_NEG_SENS, 32'(k));
            cm.send(4'h1, 16'h1000);
            rd_exp(`OFS_UP_THR, 32'h0000_1040 + 32'(12 * k));
            rd_exp(`OFS_LO_THR, 32'h0000_0FC0 - 32'(12 * k));
        end
        wr(`OFS_POS_SENS, 32'h0000_0008);
        wr(`OFS_NEG_SENS, 32'h0000_0008);
        $display("test sensitivity done");
    endtask

    task automatic test_contact();
        cm.send(4'h1, 16'h1200);
        check_flag(contact_high[1], 1'b1);
        check_flag(contact_low[1], 1'b0);
        rd_exp(`OFS_CONTACT, 32'h0000_0002);
        rd_exp(`OFS_AMBIENT, 32'h0000_1040);
        rd_exp(`OFS_UP_OFF, 32'h0000_0100);
        rd_exp(`OFS_LO_OFF, 32'h0000_FF00);
        cm.send(4'h1, 16'h1203);
        rd_exp(`OFS_AMBIENT, 32'h0000_1040);
        cm.send(4'h1, 16'h1040);
        check_flag(contact_high[1], 1'b0);
        check_flag(contact_low[1], 1'b0);
        wr(`OFS_AMBIENT, 32'h0000_1234);
        rd_exp(`OFS_AMBIENT, 32'h0000_1040);
        cm.send(4'h1, 16'h0E00);
        check_flag(contact_low[1], 1'b1);
        check_flag(contact_high[1], 1'b0);
        rd_exp(`OFS_CONTACT, 32'h0002_0000);
        $display("test contact done");
    endtask

    task automatic test_window();
        wr(`OFS_UPD_LVL, 32'h0000_FFFF);
        wr(`OFS_STAGE_SEL, 32'h0000_0002);
        wr(`OFS_UP_OFF, 32'h0000_0100);
        wr(`OFS_LO_OFF, 32'h0000_FF00);
        cm.send(4'h2, 16'h2000);
        cm.send(4'h2, 16'h2130);
        rd_exp(`OFS_UP_OFF, 32'h0000_010C);
        rd_exp(`OFS_UP_THR, 32'h0000_20A3);
        cm.send(4'h2, 16'h2200);
        rd_exp(`OFS_UP_OFF, 32'h0000_010C);
        cm.send(4'h2, 16'h1F30);
        rd_exp(`OFS_LO_OFF, 32'h0000_FF0C);
        rd_exp(`OFS_LO_THR, 32'h0000_1F63);
        cm.send(4'h2, 16'h1E00);
        rd_exp(`OFS_LO_OFF, 32'h0000_FF0C);
        $display("test window done");
    endtask

    task automatic test_clamp();
        wr(`OFS_UP_LIM, 32'h0000_0080);
        wr(`OFS_LO_LIM, 32'h0000_0080);
        rd_exp(`OFS_UP_LIM, 32'h0000_0080);
        cm.send(4'h2, 16'h2000);
        rd_exp(`OFS_UP_OFF, 32'h0000_0080);
        rd_exp(`OFS_LO_OFF, 32'h0000_FF80);
        rd_exp(`OFS_UP_THR, 32'h0000_2050);
        rd_exp(`OFS_LO_THR, 32'h0000_1FB0);
        $display("test clamp done");
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #100_000;
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_sensitivity();
        test_contact();
        test_window();
        test_clamp();
        complete_run();
    end
endmodule // adaptive_touch_threshold_test
